// ### core/smse_top.sv
`timescale 1ns/1ps
module smse_top (
   input  wire logic       CLK_IN,
   input  wire logic       RST_IN,
   input  wire logic       MASTER_MODE_IN,
   input  wire logic       TALK_ENABLE_IN,
   input  wire logic       CLOCK_PHASE_IN,
   input  wire logic       CLOCK_POLARITY_IN,
   input  wire logic [2:0] CHAR_LEN_IN,
   input  wire logic [6:0] BAUD_DIVIDER_IN,
   input  wire logic       COMPLETION_IRQ_ENABLE_IN,
   input  wire logic       OVERRUN_IRQ_ENABLE_IN,
   input  wire logic       STROBE_FUNCTION_SELECT_IN,
   input  wire logic       SOFTWARE_RESET_BIT_IN,
   input  wire logic       POWER_DOWN_IDLE_IN,
   input  wire logic       SHIFT_WRITE_IN,
   input  wire logic [7:0] SHIFT_WDATA_IN,
   input  wire logic       RXBUF_READ_IN,
   input  wire logic       OVERRUN_CLEAR_IN,
   input  wire logic       SERIAL_CLOCK_PIN_IN,
   output logic            SERIAL_CLOCK_PIN_OUT,
   output logic            SERIAL_CLOCK_PIN_OE_OUT,
   input  wire logic       MASTER_OUT_LINE_IN,
   output logic            MASTER_OUT_LINE_OUT,
   output logic            MASTER_OUT_LINE_OE_OUT,
   input  wire logic       SLAVE_OUT_LINE_IN,
   output logic            SLAVE_OUT_LINE_OUT,
   output logic            SLAVE_OUT_LINE_OE_OUT,
   input  wire logic       STROBE_PIN_IN,
   output logic            STROBE_GPIO_MODE_OUT,
   output logic [7:0]      RECEIVE_BUFFER_OUT,
   output logic [7:0]      EMULATION_BUFFER_OUT,
   output logic [7:0]      SHIFT_REGISTER_OUT,
   output logic            COMPLETION_FLAG_OUT,
   output logic            OVERRUN_FLAG_OUT,
   output logic            IRQ_OUT,
   output logic            BUSY_OUT
);
   typedef enum logic [1:0] {SMSE_IDLE, SMSE_LEAD, SMSE_RUN} smse_state_t;

   smse_state_t state_q, state_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  rxbuf_q, rxbuf_d;
   logic [3:0]  bits_q, bits_d;
   logic        inbit_q, inbit_d;
   logic        cflag_q, cflag_d;
   logic        oflag_q, oflag_d;
   logic        irq_q, irq_d;
   logic        sclk_q, sclk_d;
   logic        mosi_q, mosi_d;
   logic        miso_q, miso_d;
   logic        miso_oe_q, miso_oe_d;
   logic        sclk_oe_q, mosi_oe_q, gpio_q;
   logic        busy_q;
   logic        clk_s, clk_prev_q, mosi_s, miso_s, ste_s;
   logic        tick1, tick2;
   logic        soft_rst;
   logic        lead_edge, trail_edge, shift_edge, sample_edge;
   logic        slave_sel;
   logic        done;
   logic [3:0]  char_bits;
   logic        in_line;

   assign soft_rst  = SOFTWARE_RESET_BIT_IN;
   assign char_bits = {1'b0, CHAR_LEN_IN} + 4'h1;

   smse_sync u_sync_clk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .d_in(SERIAL_CLOCK_PIN_IN),
                         .rst_val_in(1'b0), .q_out(clk_s));
   smse_sync u_sync_mosi (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .d_in(MASTER_OUT_LINE_IN),
                          .rst_val_in(1'b0), .q_out(mosi_s));
   smse_sync u_sync_miso (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .d_in(SLAVE_OUT_LINE_IN),
                          .rst_val_in(1'b0), .q_out(miso_s));
   // Stored inverted so that after reset the select reads high (deselected).
   smse_sync u_sync_ste (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .d_in(~STROBE_PIN_IN),
                         .rst_val_in(1'b1), .q_out(ste_s));

   smse_baud u_baud (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
                     .run_in(MASTER_MODE_IN && state_q == SMSE_RUN && !soft_rst),
                     .baud_in(BAUD_DIVIDER_IN), .edge1_out(tick1), .edge2_out(tick2));

   assign slave_sel = !STROBE_FUNCTION_SELECT_IN || !ste_s;

   // Edges named by their role: the leading edge leaves idle level, trailing returns to it.
   always_comb begin
      if (MASTER_MODE_IN) begin
         lead_edge  = tick1;
         trail_edge = tick2;
      end else begin
         lead_edge  = slave_sel && (clk_s != CLOCK_POLARITY_IN) && (clk_prev_q == CLOCK_POLARITY_IN);
         trail_edge = slave_sel && (clk_s == CLOCK_POLARITY_IN) && (clk_prev_q != CLOCK_POLARITY_IN);
      end
      // without delay sample on the leading edge; with delay sample on the trailing one.
      sample_edge = CLOCK_PHASE_IN ? trail_edge : lead_edge;
      shift_edge  = CLOCK_PHASE_IN ? lead_edge : trail_edge;
      in_line     = MASTER_MODE_IN ? miso_s : mosi_s;
   end

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      rxbuf_d = rxbuf_q;
      bits_d  = bits_q;
      inbit_d = inbit_q;
      cflag_d = cflag_q;
      oflag_d = oflag_q;
      done    = 1'b0;
      if (soft_rst) begin
         state_d = SMSE_IDLE;
         bits_d  = smse_pkg::BITS_ZERO;
      end else begin
         case (state_q)
            SMSE_IDLE: begin
               if (SHIFT_WRITE_IN) begin
                  shift_d = SHIFT_WDATA_IN;
                  if (MASTER_MODE_IN) begin
                     state_d = SMSE_RUN;
                  end
               end else if (!MASTER_MODE_IN && sample_edge) begin
                  state_d = SMSE_RUN;
                  inbit_d = in_line;
               end else if (!MASTER_MODE_IN && shift_edge) begin
                  state_d = SMSE_RUN;
               end
               bits_d = smse_pkg::BITS_ZERO;
            end
            default: begin
               if (sample_edge) begin
                  inbit_d = in_line;
               end
               // Without delay the first bit out is already on the line, so shift on the trailing edge.
               if (shift_edge && (CLOCK_PHASE_IN || state_q == SMSE_RUN)) begin
                  shift_d = {shift_q[6:0], (sample_edge ? in_line : inbit_q)};
                  bits_d  = 4'(bits_q + 4'h1);
                  if (4'(bits_q + 4'h1) == char_bits) begin
                     done = 1'b1;
                  end
               end
               if (done) begin
                  state_d = SMSE_IDLE;
                  bits_d  = smse_pkg::BITS_ZERO;
                  // Upper bits keep older data shifted left, the new character ends in the low bits.
                  rxbuf_d = shift_d;
                  cflag_d = 1'b1;
                  if (cflag_q && !RXBUF_READ_IN) begin
                     oflag_d = 1'b1;
                  end
               end
            end
         endcase
      end
      // Set wins over any clear in the same cycle.
      if (!done && (RXBUF_READ_IN || POWER_DOWN_IDLE_IN || soft_rst)) begin
         cflag_d = 1'b0;
      end
      if (OVERRUN_CLEAR_IN && !(done && cflag_q && !RXBUF_READ_IN)) begin
         oflag_d = 1'b0;
      end
      irq_d = (cflag_d && COMPLETION_IRQ_ENABLE_IN) || (oflag_d && OVERRUN_IRQ_ENABLE_IN);
   end

   always_comb begin
      sclk_d    = CLOCK_POLARITY_IN;
      if (MASTER_MODE_IN && state_q == SMSE_RUN && !soft_rst) begin
         sclk_d = sclk_q;
         if (tick1) begin
            sclk_d = !CLOCK_POLARITY_IN;
         end else if (tick2) begin
            sclk_d = CLOCK_POLARITY_IN;
         end
      end
      mosi_d    = shift_d[7];
      miso_d    = shift_d[7];
      miso_oe_d = !MASTER_MODE_IN && TALK_ENABLE_IN && slave_sel;
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state_q    <= SMSE_IDLE;
         shift_q    <= smse_pkg::SHIFT_RESET;
         rxbuf_q    <= smse_pkg::RXBUF_RESET;
         bits_q     <= smse_pkg::BITS_ZERO;
         inbit_q    <= 1'b0;
         cflag_q    <= 1'b0;
         oflag_q    <= 1'b0;
         irq_q      <= 1'b0;
         sclk_q     <= 1'b0;
         mosi_q     <= 1'b0;
         miso_q     <= 1'b0;
         miso_oe_q  <= 1'b0;
         sclk_oe_q  <= 1'b0;
         mosi_oe_q  <= 1'b0;
         gpio_q     <= 1'b1;
         busy_q     <= 1'b0;
         clk_prev_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         shift_q    <= shift_d;
         rxbuf_q    <= rxbuf_d;
         bits_q     <= bits_d;
         inbit_q    <= inbit_d;
         cflag_q    <= cflag_d;
         oflag_q    <= oflag_d;
         irq_q      <= irq_d;
         sclk_q     <= sclk_d;
         mosi_q     <= mosi_d;
         miso_q     <= miso_d;
         miso_oe_q  <= miso_oe_d;
         sclk_oe_q  <= MASTER_MODE_IN;
         mosi_oe_q  <= MASTER_MODE_IN && TALK_ENABLE_IN;
         gpio_q     <= MASTER_MODE_IN || !STROBE_FUNCTION_SELECT_IN;
         busy_q     <= state_d != SMSE_IDLE;
         clk_prev_q <= clk_s;
      end
   end

   assign SERIAL_CLOCK_PIN_OUT    = sclk_q;
   assign SERIAL_CLOCK_PIN_OE_OUT = sclk_oe_q;
   assign MASTER_OUT_LINE_OUT     = mosi_q;
   assign MASTER_OUT_LINE_OE_OUT  = mosi_oe_q;
   assign SLAVE_OUT_LINE_OUT      = miso_q;
   assign SLAVE_OUT_LINE_OE_OUT   = miso_oe_q;
   assign STROBE_GPIO_MODE_OUT    = gpio_q;
   assign RECEIVE_BUFFER_OUT      = rxbuf_q;
   assign EMULATION_BUFFER_OUT    = rxbuf_q;
   assign SHIFT_REGISTER_OUT      = shift_q;
   assign COMPLETION_FLAG_OUT     = cflag_q;
   assign OVERRUN_FLAG_OUT        = oflag_q;
   assign IRQ_OUT                 = irq_q;
   assign BUSY_OUT                = busy_q;

   property p_irq_follows;
      @(posedge CLK_IN) disable iff (RST_IN)
      (cflag_q && COMPLETION_IRQ_ENABLE_IN) |=> irq_q || $past(!COMPLETION_IRQ_ENABLE_IN) || !cflag_q;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt missing for pending flag");

   property p_done_sets_flag;
      @(posedge CLK_IN) disable iff (RST_IN) done |=> cflag_q && rxbuf_q == $past(shift_d);
   endproperty
   a_done_sets_flag: assert property (p_done_sets_flag) else $error("completion not recorded");

   property p_overrun_set;
      @(posedge CLK_IN) disable iff (RST_IN) (done && cflag_q && !RXBUF_READ_IN) |=> oflag_q;
   endproperty
   a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

   property p_overrun_sticky;
      @(posedge CLK_IN) disable iff (RST_IN) (oflag_q && !OVERRUN_CLEAR_IN) |=> oflag_q;
   endproperty
   a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun dropped");

   property p_read_clears;
      @(posedge CLK_IN) disable iff (RST_IN) (RXBUF_READ_IN && !done) |=> !cflag_q;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flag not cleared by read");

   property p_talk_off;
      @(posedge CLK_IN) disable iff (RST_IN) !TALK_ENABLE_IN |=> !SLAVE_OUT_LINE_OE_OUT && !MASTER_OUT_LINE_OE_OUT;
   endproperty
   a_talk_off: assert property (p_talk_off) else $error("driving while talk is off");

   property p_master_start;
      @(posedge CLK_IN) disable iff (RST_IN)
      (state_q == SMSE_IDLE && MASTER_MODE_IN && SHIFT_WRITE_IN && !soft_rst) |=> BUSY_OUT;
   endproperty
   a_master_start: assert property (p_master_start) else $error("write did not start master");

   property p_bit_count;
      @(posedge CLK_IN) disable iff (RST_IN) bits_q <= char_bits;
   endproperty
   a_bit_count: assert property (p_bit_count) else $error("bit count beyond length");
endmodule

// ### core/smse_pkg.sv
package smse_pkg;
   localparam int          CHAR_W          = 8;
   localparam int          LEN_W           = 3;
   localparam int          BAUD_W          = 7;
   localparam logic [6:0]  BAUD_MIN        = 7'h03;
   localparam logic [7:0]  SHIFT_RESET     = 8'h00;
   localparam logic [7:0]  RXBUF_RESET     = 8'h00;
   localparam logic [3:0]  BITS_ZERO       = 4'h0;
   localparam int          SYNC_STAGES     = 3;
   localparam logic [6:0]  DIV_RESET       = 7'h00;
endpackage

// ### core/smse_sync.sv
`timescale 1ns/1ps
// Three-stage input synchroniser; the output only moves when stages two and three agree.
module smse_sync (
   input  wire logic CLK_IN,
   input  wire logic RST_IN,
   input  wire logic d_in,
   input  wire logic rst_val_in,
   output logic      q_out
);
   logic s1_q, s2_q, s3_q, q_q;
   logic q_d;

   always_comb begin
      q_d = q_q;
      if (s2_q == s3_q) begin
         q_d = s3_q;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_q  <= 1'b0;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q  <= q_d;
      end
   end

   assign q_out = q_q ^ rst_val_in;
endmodule

// ### core/smse_baud.sv
`timescale 1ns/1ps
// Master bit-rate divider: one half-period tick pair per bit, the half after edge1 takes the extra cycle on odd counts.
module smse_baud (
   input  wire logic       CLK_IN,
   input  wire logic       RST_IN,
   input  wire logic       run_in,
   input  wire logic [6:0] baud_in,
   output logic            edge1_out,
   output logic            edge2_out
);
   logic [6:0] cnt_q, cnt_d;
   logic       half_q, half_d;
   logic [7:0] period;
   logic [6:0] first_len;
   logic [6:0] second_len;

   always_comb begin
      // Settings below the minimum all give the fastest rate of a quarter of the clock.
      period     = (baud_in < smse_pkg::BAUD_MIN) ? 8'h04 : ({1'b0, baud_in} + 8'h01);
      first_len  = period[7:1];
      second_len = 7'(period - {1'b0, period[7:1]});
      cnt_d      = cnt_q;
      half_d     = half_q;
      edge1_out  = 1'b0;
      edge2_out  = 1'b0;
      if (!run_in) begin
         cnt_d  = smse_pkg::DIV_RESET;
         half_d = 1'b0;
      end else if (!half_q && cnt_q == 7'(first_len - 7'h01)) begin
         cnt_d     = smse_pkg::DIV_RESET;
         half_d    = 1'b1;
         edge1_out = 1'b1;
      end else if (half_q && cnt_q == 7'(second_len - 7'h01)) begin
         cnt_d     = smse_pkg::DIV_RESET;
         half_d    = 1'b0;
         edge2_out = 1'b1;
      end else begin
         cnt_d = 7'(cnt_q + 7'h01);
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cnt_q  <= smse_pkg::DIV_RESET;
         half_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         half_q <= half_d;
      end
   end
endmodule

// ### test/smse_peer.sv
`timescale 1ns/1ps
// Far-side party with polarity 0 and phase 0: an SPI slave, or a slow master while role_q is set.
module smse_peer (
   input  wire logic sclk_in,
   input  wire logic mosi_in,
   input  wire logic miso_in,
   input  wire logic sel_n_in,
   output logic      sclk_out,
   output logic      mosi_out,
   output logic      miso_out,
   output logic      ste_n_out
);
   logic       role_q = 1'b0;
   logic [7:0] tx_q   = 8'h00;
   logic [7:0] rx_q   = 8'h00;

   initial begin
      sclk_out = 1'b0;
      ste_n_out = 1'b1;
   end

   // A released line shows the inverse of its last bit, so a stale value never passes for data.
   assign miso_out = (!role_q && !sel_n_in) ? tx_q[7] : ~tx_q[7];
   assign mosi_out = role_q ? tx_q[7] : ~tx_q[7];

   always @(posedge sclk_in) begin
      if (role_q || !sel_n_in) begin
         rx_q <= {rx_q[6:0], (role_q ? miso_in : mosi_in)};
      end
   end

   always @(negedge sclk_in) begin
      if (role_q || !sel_n_in) begin
         tx_q <= {tx_q[6:0], ~tx_q[0]};
      end
   end

   // Half period of 80 ns keeps the clock at one sixteenth of the system clock.
   task automatic run(input int n, input int half);
      ste_n_out = 1'b0;
      #(half);
      repeat (n) begin
         sclk_out = 1'b1;
         #(half);
         sclk_out = 1'b0;
         #(half);
      end
      ste_n_out = 1'b1;
   endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
   logic       clk, rst, mstr, talk, cie, oie, ssel, swr, pdi, wr, rd, oclr, sel_n;
   logic [2:0] len;
   logic [6:0] div;
   logic [7:0] wdata, e_w, rxbuf, emu, shreg, r, pd;
   logic       sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic       gpio, cflag, oflag, irq, busy, cflag_p, oflag_p;
   wire        p_sclk, p_mosi, p_miso, p_ste_n, sclk_w, mosi_w, miso_w;
   int         error_cnt = 0;
   int         n_compared = 0;
   logic [7:0] exp_q[$];

   assign sclk_w = sclk_oe ? sclk_o : p_sclk;
   assign mosi_w = mosi_oe ? mosi_o : p_mosi;
   assign miso_w = miso_oe ? miso_o : p_miso;

   smse_top i_smse_top (.CLK_IN(clk), .RST_IN(rst), .MASTER_MODE_IN(mstr), .TALK_ENABLE_IN(talk),
      .CLOCK_PHASE_IN(1'b0), .CLOCK_POLARITY_IN(1'b0), .CHAR_LEN_IN(len), .BAUD_DIVIDER_IN(div),
      .COMPLETION_IRQ_ENABLE_IN(cie), .OVERRUN_IRQ_ENABLE_IN(oie), .STROBE_FUNCTION_SELECT_IN(ssel),
      .SOFTWARE_RESET_BIT_IN(swr), .POWER_DOWN_IDLE_IN(pdi), .SHIFT_WRITE_IN(wr), .SHIFT_WDATA_IN(wdata),
      .RXBUF_READ_IN(rd), .OVERRUN_CLEAR_IN(oclr), .SERIAL_CLOCK_PIN_IN(sclk_w),
      .SERIAL_CLOCK_PIN_OUT(sclk_o), .SERIAL_CLOCK_PIN_OE_OUT(sclk_oe), .MASTER_OUT_LINE_IN(mosi_w),
      .MASTER_OUT_LINE_OUT(mosi_o), .MASTER_OUT_LINE_OE_OUT(mosi_oe), .SLAVE_OUT_LINE_IN(miso_w),
      .SLAVE_OUT_LINE_OUT(miso_o), .SLAVE_OUT_LINE_OE_OUT(miso_oe), .STROBE_PIN_IN(p_ste_n),
      .STROBE_GPIO_MODE_OUT(gpio), .RECEIVE_BUFFER_OUT(rxbuf), .EMULATION_BUFFER_OUT(emu),
      .SHIFT_REGISTER_OUT(shreg), .COMPLETION_FLAG_OUT(cflag), .OVERRUN_FLAG_OUT(oflag),
      .IRQ_OUT(irq), .BUSY_OUT(busy));

   smse_peer i_smse_peer (.sclk_in(sclk_w), .mosi_in(mosi_w), .miso_in(miso_w), .sel_n_in(sel_n),
      .sclk_out(p_sclk), .mosi_out(p_mosi), .miso_out(p_miso), .ste_n_out(p_ste_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic clr(input int k);
      case (k)
         0: rd = 1'b1;
         1: swr = 1'b1;
         2: pdi = 1'b1;
         default: oclr = 1'b1;
      endcase
      tick(1);
      {rd, swr, pdi, oclr} = 4'h0;
      tick(1);
   endtask

   // Leftover bits of the written character move up by n, so the whole buffer is predictable.
   task automatic xfer(input int n, input logic [7:0] d, input logic [7:0] pdat, input bit q);
      logic [7:0] e;
      int         k;
      len = 3'(n - 1);
      i_smse_peer.tx_q = pdat;
      i_smse_peer.rx_q = 8'h00;
      e = 8'((d << n) | (pdat >> (8 - n)));
      if (q) begin
         exp_q.push_back(e);
      end
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
         tick(1);
         k++;
      end
      if (k == 5000) begin
         error_cnt++;
         end_sim();
      end
      tick(2);
      `CHK(i_smse_peer.rx_q, d >> (8 - n))
      `CHK(cflag, 1'b1)
      `CHK(rxbuf, e)
      `CHK(mosi_oe, 1'b1)
   endtask

   always @(posedge clk) begin
      cflag_p <= cflag;
      oflag_p <= oflag;
      if (!rst && ((cflag && !cflag_p) || (oflag && !oflag_p))) begin
         if (exp_q.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            e_w = exp_q.pop_front();
            `CHK(rxbuf, e_w)
         end
      end
   end

   initial begin
      {rst, mstr, talk, cie, oie, ssel, swr, pdi, wr, rd, oclr, sel_n} = 12'h801;
      len = 3'h0;
      div = 7'h00;
      wdata = 8'h00;
      void'($urandom(96));
      tick(4);
      rst = 1'b0;
      `CHK({gpio, cflag, oflag, irq, busy}, 5'h10)
      `CHK({rxbuf, emu, shreg}, 24'h000000)
      {mstr, talk, ssel, sel_n} = 4'he;
      tick(2);
      `CHK(gpio, 1'b1)
      `CHK(sclk_oe, 1'b1)
      for (int n = 1; n <= 8; n++) begin
         // The slave-out pin passes the three-stage synchroniser, about four clocks of delay.
         // A bit is captured reliably only when the first half of the bit lasts at least five clocks.
         // Below a divider of 9 the master would capture stale bits, so the random range starts there.
         div = (n == 8) ? 7'h7f : 7'($urandom_range(40, 9));
         xfer(n, 8'($urandom), 8'($urandom), 1'b1);
         clr(0);
         `CHK(cflag, 1'b0)
      end
      for (int k = 0; k < 3; k++) begin
         xfer(8, 8'($urandom), 8'($urandom), 1'b1);
         tick(2);
         `CHK(irq, 1'b0)
         cie = 1'b1;
         tick(2);
         `CHK(irq, 1'b1)
         clr(k);
         `CHK({cflag, irq}, 2'h0)
         cie = 1'b0;
      end
      xfer(8, 8'($urandom), 8'($urandom), 1'b1);
      xfer(8, 8'($urandom), 8'($urandom), 1'b1);
      `CHK(oflag, 1'b1)
      oie = 1'b1;
      tick(2);
      `CHK(irq, 1'b1)
      xfer(5, 8'($urandom), 8'($urandom), 1'b0);
      clr(0);
      `CHK(oflag, 1'b1)
      clr(3);
      `CHK({oflag, irq}, 2'h0)
      oie = 1'b0;
      {mstr, sel_n} = 2'h1;
      len = 3'h7;
      tick(6);
      `CHK({gpio, sclk_oe, miso_oe}, 3'h0)
      r = 8'($urandom);
      pd = 8'($urandom);
      wdata = r;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      i_smse_peer.tx_q = pd;
      i_smse_peer.rx_q = 8'h00;
      i_smse_peer.role_q = 1'b1;
      exp_q.push_back(pd);
      i_smse_peer.run(8, 80);
      tick(8);
      `CHK(i_smse_peer.rx_q, r)
      `CHK({cflag, rxbuf}, {1'b1, pd})
      i_smse_peer.ste_n_out = 1'b0;
      talk = 1'b0;
      tick(6);
      `CHK(miso_oe, 1'b0)
      talk = 1'b1;
      tick(6);
      `CHK(miso_oe, 1'b1)
      i_smse_peer.ste_n_out = 1'b1;
      tick(6);
      `CHK(miso_oe, 1'b0)
      ssel = 1'b0;
      tick(2);
      `CHK(gpio, 1'b1)
      `CHK(exp_q.size(), 0)
      end_sim();
   end
endmodule
